// *** src/sysref_release_map.svh ***
// Behaviour
// - Selector zero: idle outputs static low/high
// - Selector one: idle outputs cross-point biased
// - Bias selector one RW bit, resets one
// - Pulses released only on coincident divider edges
// - Mode bit zero: low stage only, 2..9
// - Mode bit one: middle times low stage
// - Low codes 000..110 give 2..8, 111 nine
// - Middle stage ratios 2,4,6,8,12,16; 111 sixteen
// - Request restarts both divider stages to realign outputs
`ifndef SYSREF_RELEASE_MAP_SVH
`define SYSREF_RELEASE_MAP_SVH

// Register indices on the configuration port
`define SRD_IDX_BIAS 1'b0
`define SRD_IDX_RATIO 1'b1

// Reset values
`define SRD_BIAS_RESET 1'b1
`define SRD_RATIO_RESET 7'h01

// Field positions of the release ratio register
`define SRD_MODE_BIT 6
`define SRD_MID_MSB 5
`define SRD_MID_LSB 3
`define SRD_LOW_MSB 2
`define SRD_LOW_LSB 0

// Stage ratio figures
`define SRD_LOW_BASE 5'h02
`define SRD_LOW_TOP_CODE 3'h7
`define SRD_LOW_TOP_RATIO 5'h09
`define SRD_MID_R2 5'h02
`define SRD_MID_R4 5'h04
`define SRD_MID_R6 5'h06
`define SRD_MID_R8 5'h08
`define SRD_MID_R12 5'h0c
`define SRD_MID_R16 5'h10

// Number of SYSREF outputs handled
`define SRD_OUTPUTS 8

`endif

// *** src/sysref_release_pkg.sv ***
`default_nettype none
package sysref_release_pkg;

	// How one SYSREF output is driven
	typedef enum logic [1:0] {
		drv_active,
		drv_static,
		drv_cross_bias
	} sysref_drive_t;

	// Decoded release divider configuration
	typedef struct packed {
		logic cascade;
		logic [4:0] mid_ratio;
		logic [4:0] low_ratio;
	} release_cfg_t;

endpackage : sysref_release_pkg
`default_nettype wire

// *** src/stage_counter.sv ***
`default_nettype none
module stage_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic restart,
	input wire logic step,
	input wire logic [4:0] ratio,
	// Terminal count
	output logic tc
);

	logic [4:0] count;
	logic [4:0] last;

	// Last count value before wrap
	assign last = ratio - 5'h01;
	assign tc = step && !restart && (count >= last);

	// Modulo counter, cleared on restart
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 5'h00;
		end else if (restart) begin
			count <= 5'h00;
		end else if (step) begin
			if (count >= last) begin
				count <= 5'h00;
			end else begin
				count <= count + 5'h01;
			end
		end
	end

endmodule : stage_counter
`default_nettype wire

// *** src/sysref_release_divider.sv ***
`include "sysref_release_map.svh"
`default_nettype none
module sysref_release_divider (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Configuration port
	input wire logic reg_wr,
	input wire logic reg_sel,
	input wire logic [7:0] reg_wdata,
	output logic rd_bias,
	output logic [6:0] rd_ratio,
	// SYSREF control
	input wire logic sysref_request,
	input wire logic pulse_req,
	input wire logic [`SRD_OUTPUTS-1:0] per_output_bias_off,
	// SYSREF outputs
	output logic [`SRD_OUTPUTS-1:0] sysref_output,
	output var sysref_release_pkg::sysref_drive_t [`SRD_OUTPUTS-1:0] output_drive,
	output logic event_busy,
	output logic release_tick
);

	////////////////////////////////////////////////////////////////
	// Registers
	// Two software registers on a plain write port

	// Stored configuration and its decoded view
	logic sysref_idle_bias_select;
	logic [6:0] sysref_release_ratio;
	sysref_release_pkg::release_cfg_t cfg;

	// Write strobes
	logic wr_bias;
	logic wr_ratio;

	// Write strobes per register index
	assign wr_bias = reg_wr && (reg_sel == `SRD_IDX_BIAS);
	assign wr_ratio = reg_wr && (reg_sel == `SRD_IDX_RATIO);

	// Bias selector write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sysref_idle_bias_select <= `SRD_BIAS_RESET;
		end else if (wr_bias) begin
			sysref_idle_bias_select <= reg_wdata[0];
		end
	end

	// Release ratio write; a new ratio takes effect on the next count
	// Counters compare with >= so a smaller ratio wraps at once
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sysref_release_ratio <= `SRD_RATIO_RESET;
		end else if (wr_ratio) begin
			sysref_release_ratio <= reg_wdata[6:0];
		end
	end

	// Readback straight from the registers
	assign rd_bias = sysref_idle_bias_select;
	assign rd_ratio = sysref_release_ratio;

	////////////////////////////////////////////////////////////////
	// Ratio decode

	// Low stage code to ratio
	function automatic logic [4:0] low_decode(input logic [2:0] code);
		if (code == `SRD_LOW_TOP_CODE) begin
			low_decode = `SRD_LOW_TOP_RATIO;
		end else begin
			low_decode = `SRD_LOW_BASE + {2'b00, code};
		end
	endfunction : low_decode

	// Middle stage code to ratio; codes five and up all give sixteen
	function automatic logic [4:0] mid_decode(input logic [2:0] code);
		unique case (code)
			3'h0: mid_decode = `SRD_MID_R2;
			3'h1: mid_decode = `SRD_MID_R4;
			3'h2: mid_decode = `SRD_MID_R6;
			3'h3: mid_decode = `SRD_MID_R8;
			3'h4: mid_decode = `SRD_MID_R12;
			3'h5: mid_decode = `SRD_MID_R16;
			3'h6: mid_decode = `SRD_MID_R16;
			3'h7: mid_decode = `SRD_MID_R16;
		endcase
	endfunction : mid_decode

	// Decoded configuration
	// Mode bit picks one stage or the product of both
	always_comb begin
		cfg.cascade = sysref_release_ratio[`SRD_MODE_BIT];
		cfg.mid_ratio = mid_decode(sysref_release_ratio[`SRD_MID_MSB:`SRD_MID_LSB]);
		cfg.low_ratio = low_decode(sysref_release_ratio[`SRD_LOW_MSB:`SRD_LOW_LSB]);
	end

	////////////////////////////////////////////////////////////////
	// Cascaded release counters

	// Restart strobe and stage terminal counts
	logic realign;
	logic low_tc;
	logic mid_tc;
	logic common_tc;

	// Low stage steps every device clock
	stage_counter low_stage (
		.clk(clk),
		.rst_b(rst_b),
		.restart(realign),
		.step(1'b1),
		.ratio(cfg.low_ratio),
		.tc(low_tc)
	);

	// Middle stage steps on low stage wrap
	stage_counter mid_stage (
		.clk(clk),
		.rst_b(rst_b),
		.restart(realign),
		.step(low_tc),
		.ratio(cfg.mid_ratio),
		.tc(mid_tc)
	);

	// Common terminal count of the active stages
	// Middle stage runs unused while cascade is off
	assign common_tc = cfg.cascade ? mid_tc : low_tc;
	assign release_tick = common_tc;

	////////////////////////////////////////////////////////////////
	// Request alignment and pulse release

	// Pulse bookkeeping
	logic pending;
	logic release_now;
	logic busy_end;

	// Request restarts the dividers one cycle later;
	// the restart cycle drops the tick of the old phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			realign <= 1'b0;
		end else begin
			realign <= sysref_request;
		end
	end

	// Event ends at the first tick of the new phase
	assign busy_end = common_tc && !realign;

	// Event busy from request to first aligned terminal count
	// A repeated request stretches the window again
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			event_busy <= 1'b0;
		end else if (sysref_request) begin
			event_busy <= 1'b1;
		end else if (busy_end) begin
			event_busy <= 1'b0;
		end
	end

	// Release only on a common tick outside an event
	assign release_now = pending && common_tc && !event_busy;

	// Pending pulse; a new request wins over release
	// Several requests before one tick merge into one pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pending <= 1'b0;
		end else if (pulse_req) begin
			pending <= 1'b1;
		end else if (release_now) begin
			pending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Output drive

	// Outputs held idle by their own control or an event
	logic [`SRD_OUTPUTS-1:0] idle;
	assign idle = per_output_bias_off | {`SRD_OUTPUTS{event_busy}};

	// Output level: idle lanes sit low, live lanes carry the pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sysref_output <= '0;
		end else begin
			for (int i = 0; i < `SRD_OUTPUTS; i++) begin
				if (idle[i]) begin
					sysref_output[i] <= 1'b0;
				end else begin
					sysref_output[i] <= release_now;
				end
			end
		end
	end

	// Drive state: live, static or cross-point biased
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < `SRD_OUTPUTS; i++) begin
				output_drive[i] <= sysref_release_pkg::drv_cross_bias;
			end
		end else begin
			for (int i = 0; i < `SRD_OUTPUTS; i++) begin
				if (!idle[i]) begin
					output_drive[i] <= sysref_release_pkg::drv_active;
				end else if (sysref_idle_bias_select) begin
					output_drive[i] <= sysref_release_pkg::drv_cross_bias;
				end else begin
					output_drive[i] <= sysref_release_pkg::drv_static;
				end
			end
		end
	end

endmodule : sysref_release_divider
`default_nettype wire

// *** verif/sysref_release_props.sv ***
`default_nettype none
module sysref_release_props (
	// Watched design ports
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reg_wr,
	input wire logic reg_sel,
	input wire logic [7:0] reg_wdata,
	input wire logic rd_bias,
	input wire logic [6:0] rd_ratio,
	input wire logic sysref_request,
	input wire logic [7:0] per_output_bias_off,
	input wire logic [7:0] sysref_output,
	input wire sysref_release_pkg::sysref_drive_t [7:0] output_drive,
	input wire logic event_busy,
	input wire logic release_tick
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Register, drive and release relations
	a_bias_write: assert property (reg_wr && !reg_sel |=> rd_bias == $past(reg_wdata[0]))
		else $error("bias readback wrong");
	a_ratio_write: assert property (reg_wr && reg_sel |=> rd_ratio == $past(reg_wdata[6:0]))
		else $error("ratio readback wrong");
	a_drive_idle: assert property (per_output_bias_off[0] |=> output_drive[0] ==
		($past(rd_bias) ? sysref_release_pkg::drv_cross_bias : sysref_release_pkg::drv_static))
		else $error("idle drive wrong");
	a_off_low: assert property (per_output_bias_off[0] |=> !sysref_output[0])
		else $error("bias-off output pulsed");
	a_busy_quiet: assert property (event_busy && $past(event_busy) |-> sysref_output == 8'h00)
		else $error("pulse during event");
	a_pulse_tick: assert property ($rose(sysref_output[1]) |-> $past(release_tick) && !$past(event_busy))
		else $error("pulse off tick");
	a_pulse_one: assert property (sysref_output[1] |=> !sysref_output[1])
		else $error("pulse too long");
	a_tick_gap: assert property (release_tick |=> !release_tick)
		else $error("ticks adjacent");
	a_req_busy: assert property (sysref_request |=> event_busy)
		else $error("request not busy");
	a_busy_end: assert property ($rose(event_busy) |-> ##[1:300] !event_busy)
		else $error("event never ends");
	c_tick: cover property (release_tick);
	c_pulse: cover property (sysref_output[1]);
	c_busy: cover property ($fell(event_busy));
	c_cross: cover property (output_drive[0] == sysref_release_pkg::drv_cross_bias && per_output_bias_off[0]);
endmodule : sysref_release_props
`default_nettype wire

// *** verif/sysref_sink.sv ***
`default_nettype none
module sysref_sink (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// SYSREF lanes from the divider
	input wire logic [7:0] sysref_output,
	// Pulses seen on the last lane
	output logic [7:0] pulse_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last;
	// Count rising edges like a converter latching SYSREF
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			last <= 1'b0;
			pulse_cnt <= 8'h00;
		end else begin
			last <= sysref_output[7];
			pulse_cnt <= pulse_cnt + 8'(sysref_output[7] && !last);
		end
	end
endmodule : sysref_sink
`default_nettype wire

// *** verif/testbench.sv ***
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, reg_wr = 0, reg_sel = 0, sysref_request = 0, pulse_req = 0;
	logic [7:0] reg_wdata = 8'h00, per_output_bias_off = 8'h00, sysref_output, pulse_cnt;
	logic rd_bias, event_busy, release_tick;
	logic [6:0] rd_ratio;
	sysref_release_pkg::sysref_drive_t [7:0] output_drive;
	int n_fail = 0, num_checks = 0, cyc = 0;
	int mid [8] = '{2, 4, 6, 8, 12, 16, 16, 16};
	// Block under test
	sysref_release_divider i_sysref_release_divider (
		.clk(clk),
		.rst_b(rst_b),
		.reg_wr(reg_wr),
		.reg_sel(reg_sel),
		.reg_wdata(reg_wdata),
		.rd_bias(rd_bias),
		.rd_ratio(rd_ratio),
		.sysref_request(sysref_request),
		.pulse_req(pulse_req),
		.per_output_bias_off(per_output_bias_off),
		.sysref_output(sysref_output),
		.output_drive(output_drive),
		.event_busy(event_busy),
		.release_tick(release_tick)
	);
	// Converter side
	sysref_sink i_sysref_sink (
		.clk(clk),
		.rst_b(rst_b),
		.sysref_output(sysref_output),
		.pulse_cnt(pulse_cnt)
	);
	always #5 clk = ~clk;
	// Cycle ceiling against a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic conclude();
		if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic wr(logic s, logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_sel <= s;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(negedge clk);
	endtask : wr
	// Cycles up to the next release tick
	task automatic gap(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (release_tick !== 1'b1 && n < 300);
	endtask : gap
	// Tick spacing for every low code and every middle code
	task automatic t_ratio();
		int n;
		logic [6:0] c;
		for (int k = 0; k < 16; k++) begin
			c = (k < 8) ? 7'(k) : {1'b1, 3'(k), 3'h0};
			wr(1'b1, {1'b0, c});
			chk("rd_ratio", 16'(rd_ratio), 16'(c));
			repeat (3) gap(n);
			chk("gap", 16'(n), k < 8 ? 16'(k + 2) : 16'(mid[k % 8] * 2));
		end
	endtask : t_ratio
	// Two merged requests give one pulse, lane 0 kept off
	task automatic t_pulse();
		int n = 0;
		wr(1'b1, 8'h44);
		gap(n);
		@(posedge clk);
		per_output_bias_off <= 8'h01;
		pulse_req <= 1'b1;
		repeat (2) @(posedge clk);
		pulse_req <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sysref_output === 8'h00 && n < 60);
		chk("pulse", 16'(sysref_output), 16'h00fe);
		repeat (30) @(negedge clk);
		chk("count", 16'(pulse_cnt), 16'h0001);
	endtask : t_pulse
	// Idle drive follows the bias selector
	task automatic t_bias();
		wr(1'b0, 8'h00);
		chk("rd_bias", 16'(rd_bias), 16'h0000);
		@(negedge clk);
		chk("static", 16'(output_drive[0]), 16'(sysref_release_pkg::drv_static));
		chk("live", 16'(output_drive[1]), 16'(sysref_release_pkg::drv_active));
		wr(1'b0, 8'h01);
		@(negedge clk);
		chk("cross", 16'(output_drive[0]), 16'(sysref_release_pkg::drv_cross_bias));
	endtask : t_bias
	// Request realigns: pulse held back until event ends
	task automatic t_req();
		int n = 0;
		logic hit = 1'b0;
		@(posedge clk);
		pulse_req <= 1'b1;
		sysref_request <= 1'b1;
		@(posedge clk);
		pulse_req <= 1'b0;
		sysref_request <= 1'b0;
		@(negedge clk);
		chk("busy", 16'(event_busy), 16'h0001);
		while (event_busy === 1'b1 && n < 300) begin
			@(negedge clk);
			hit = hit | (|sysref_output);
			n++;
		end
		chk("quiet", 16'(hit), 16'h0000);
		chk("busy_len", 16'(n), 16'(1 + 12));
		repeat (30) @(negedge clk);
		chk("count", 16'(pulse_cnt), 16'h0002);
	endtask : t_req
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk("rd_bias", 16'(rd_bias), 16'h0001);
		chk("rd_ratio", 16'(rd_ratio), 16'h0001);
		chk("drive_rst", 16'(output_drive[0]), 16'(sysref_release_pkg::drv_cross_bias));
		chk("busy_rst", 16'(event_busy), 16'h0000);
		t_ratio();
		t_pulse();
		t_bias();
		t_req();
		conclude();
	end
endmodule : testbench
bind sysref_release_divider sysref_release_props i_sysref_release_props (
	.clk(clk),
	.rst_b(rst_b),
	.reg_wr(reg_wr),
	.reg_sel(reg_sel),
	.reg_wdata(reg_wdata),
	.rd_bias(rd_bias),
	.rd_ratio(rd_ratio),
	.sysref_request(sysref_request),
	.per_output_bias_off(per_output_bias_off),
	.sysref_output(sysref_output),
	.output_drive(output_drive),
	.event_busy(event_busy),
	.release_tick(release_tick)
);
`default_nettype wire
